// file: asbm_pkg.sv
// Shared constants for the sample bus-master transfer engine.
// Assumes a 100 MHz system clock and a byte-addressed host memory space.
package asbm_pkg;
  localparam int unsigned SAMPLE_W      = 16;
  localparam int unsigned WORD_W        = 32;
  localparam int unsigned RING_BYTES    = 262144;
  localparam int unsigned HALF_BYTES    = 131072;
  localparam int unsigned WORD_BYTES    = 4;
  localparam int unsigned RING_WORDS    = RING_BYTES / WORD_BYTES;
  localparam int unsigned HALF_WORDS    = HALF_BYTES / WORD_BYTES;
  localparam int unsigned WIDX_W        = 16;
  localparam int unsigned ADDR_W        = 32;
  localparam int unsigned REG_ADDR_W    = 4;
  // Register map (word offsets)
  localparam logic [3:0] REG_CTRL       = 4'h0;
  localparam logic [3:0] REG_STATUS     = 4'h1;
  localparam logic [3:0] REG_ERR        = 4'h2;
  localparam logic [3:0] REG_BASE       = 4'h3;
  localparam logic [3:0] REG_WPTR       = 4'h4;
  localparam logic [3:0] REG_TRIGPOS    = 4'h5;
  localparam logic [3:0] REG_HALFDONE   = 4'h6;
  // Control bits
  localparam int unsigned CTRL_RUN      = 0;
  localparam int unsigned CTRL_STOP     = 1;
  localparam int unsigned CTRL_BIPOLAR  = 2;
  // Error bits
  localparam int unsigned ERR_OVERRUN   = 0;
  localparam int unsigned ERR_FIFO      = 1;
  localparam int unsigned ERR_BLOCK     = 2;
  // Half-done / consumed bits
  localparam int unsigned HALF0         = 0;
  localparam int unsigned HALF1         = 1;
  localparam logic [31:0] BASE_RST      = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
endpackage

// file: asbm_fifo_if.sv
// Carries tagged samples from the input FIFO to the transfer engine.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface asbm_fifo_if;
  logic                          valid;
  logic                          ready;
  logic [asbm_pkg::SAMPLE_W-1:0] data;
  logic                          post;
  logic                          full;
  modport src (output valid, output data, output post, output full, input ready);
  modport snk (input valid, input data, input post, input full, output ready);
endinterface
`default_nettype wire

// file: asbm_in_fifo.sv
// Input sample FIFO holding converted samples with their trigger marker.
// Assumes samples arrive as one-cycle pulses on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module asbm_in_fifo #(
  parameter int unsigned DEPTH_LOG2 = 4
) (
  input  wire logic                          sys_clk,
  input  wire logic                          reset,
  input  wire logic                          flush,
  input  wire logic                          wr_en,
  input  wire logic [asbm_pkg::SAMPLE_W-1:0] wr_data,
  input  wire logic                          wr_post,
  asbm_fifo_if.src                           rd
);
  localparam int unsigned DEPTH = 1 << DEPTH_LOG2;
  logic [asbm_pkg::SAMPLE_W:0] mem [DEPTH];
  logic [DEPTH_LOG2:0]         wptr_q;
  logic [DEPTH_LOG2:0]         rptr_q;
  logic                        full;
  logic                        empty;

  assign full  = (wptr_q[DEPTH_LOG2] != rptr_q[DEPTH_LOG2]) &&
                 (wptr_q[DEPTH_LOG2-1:0] == rptr_q[DEPTH_LOG2-1:0]);
  assign empty = (wptr_q == rptr_q);

  always_ff @(posedge sys_clk) begin
    if (wr_en && !full) begin
      mem[wptr_q[DEPTH_LOG2-1:0]] <= {wr_post, wr_data};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || flush) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      if (wr_en && !full) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (rd.ready && !empty) begin
        rptr_q <= rptr_q + 1'b1;
      end
    end
  end

  assign rd.valid = !empty;
  assign rd.data  = mem[rptr_q[DEPTH_LOG2-1:0]][asbm_pkg::SAMPLE_W-1:0];
  assign rd.post  = mem[rptr_q[DEPTH_LOG2-1:0]][asbm_pkg::SAMPLE_W];
  assign rd.full  = full;
endmodule
`default_nettype wire

// file: asbm_top.sv
// Bus-master transfer engine moving sample pairs into a host ring buffer.
// Assumes a simple bus-master write port that accepts a word when ready.
// Host software marks halves consumed through the half-done register.
//
// Operation
// - Each transfer carries one even, one odd sample
// - Pre/post marker kept internally, never transferred
// - Readable register gives post-trigger start position
// - Samples reach host only by device writes
// - Master writes into dedicated 256KB ring
// - Ring handled as two 128KB halves
// - Stop with odd sample still sends pair
// - Sample clock while converter busy flags overrun
// - Full input FIFO flags FIFO overflow
// - Clear while FIFO full raises error again
// - Half done before host consumed flags overflow
// - Errors stay set until host clears them
// - Any error halts acquisition and transfers
// - Samples sent as offset binary
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module asbm_top #(
  parameter int unsigned FIFO_DEPTH_LOG2 = 4
) (
  input  wire logic                            sys_clk,
  input  wire logic                            reset,
  // Register port
  input  wire logic [asbm_pkg::REG_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]                     reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [31:0]                     reg_rdata,
  // Converter side
  input  wire logic                            sample_clk,
  input  wire logic                            adc_busy,
  input  wire logic                            adc_done,
  input  wire logic [asbm_pkg::SAMPLE_W-1:0]   adc_data,
  input  wire logic                            trig_post,
  // Bus-master write port, then the acquisition run flag
  output logic                                 mst_req,
  output logic      [asbm_pkg::ADDR_W-1:0]     mst_addr,
  output logic      [asbm_pkg::WORD_W-1:0]     mst_data,
  input  wire logic                            mst_ack,
  output logic                                 acq_run
);
  localparam int unsigned SW = asbm_pkg::SAMPLE_W;

  typedef enum logic [1:0] {ASBM_IDLE, ASBM_EVEN, ASBM_ODD, ASBM_SEND} asbm_state_t;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0] sclk_s_q;
  logic [1:0] busy_s_q;
  logic [1:0] trig_s_q;
  logic       sclk_prev_q;
  logic       sclk_rise;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sclk_s_q    <= '0;
      busy_s_q    <= '0;
      trig_s_q    <= '0;
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_s_q    <= {sclk_s_q[0], sample_clk};
      busy_s_q    <= {busy_s_q[0], adc_busy};
      trig_s_q    <= {trig_s_q[0], trig_post};
      sclk_prev_q <= sclk_s_q[1];
    end
  end
  // Previous value resets low like the idle pin, so reset makes no false edge
  assign sclk_rise = sclk_s_q[1] && !sclk_prev_q;

  // ****************************************
  // Registers
  // ****************************************
  logic        run_q;
  logic        bipolar_q;
  logic        stop_req_q;
  logic [31:0] base_q;
  logic [2:0]  err_q;
  logic [1:0]  half_done_q;
  logic [1:0]  consumed_wr;
  logic [2:0]  err_clr;
  logic        any_err;
  logic        post_seen_q;
  logic        trig_valid_q;
  logic [31:0] trig_pos_q;
  logic [asbm_pkg::WIDX_W-1:0] widx_q;
  logic        sel_ctrl;
  logic        sel_err;
  logic        sel_half;
  logic        run_wr;

  assign sel_ctrl    = reg_wr && (reg_addr == asbm_pkg::REG_CTRL);
  assign run_wr      = sel_ctrl && reg_wdata[asbm_pkg::CTRL_RUN];
  assign sel_err     = reg_wr && (reg_addr == asbm_pkg::REG_ERR);
  assign sel_half    = reg_wr && (reg_addr == asbm_pkg::REG_HALFDONE);
  assign err_clr     = sel_err ? reg_wdata[2:0] : 3'h0;
  assign consumed_wr = sel_half ? reg_wdata[1:0] : 2'h0;
  assign any_err     = |err_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bipolar_q <= 1'b0;
      base_q    <= asbm_pkg::BASE_RST;
    end else begin
      if (sel_ctrl) begin
        bipolar_q <= reg_wdata[asbm_pkg::CTRL_BIPOLAR];
      end
      if (reg_wr && (reg_addr == asbm_pkg::REG_BASE)) begin
        base_q <= reg_wdata;
      end
    end
  end

  // ****************************************
  // Acquisition and error flags
  // ****************************************
  logic fifo_full;
  logic set_ovr;
  logic set_fifo;
  logic set_blk;
  logic acq_en;

  asbm_fifo_if fif ();

  // Stop, error or idle all keep new samples out of the FIFO
  assign acq_en  = run_q && !stop_req_q && !any_err;
  assign set_ovr = acq_en && sclk_rise && busy_s_q[1];
  // Not gated by run: a clear while the FIFO stays full must re-raise the flag
  assign set_fifo = fifo_full;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      err_q <= 3'h0;
    end else begin
      // Set wins over clear, so a clear while full re-raises at once
      err_q <= (err_q & ~err_clr) |
               {set_blk, set_fifo, set_ovr};
    end
  end

  // ****************************************
  // Run control
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      run_q      <= 1'b0;
      stop_req_q <= 1'b0;
    end else if (sel_ctrl && reg_wdata[asbm_pkg::CTRL_RUN]) begin
      run_q      <= 1'b1;
      stop_req_q <= 1'b0;
    end else if (sel_ctrl && reg_wdata[asbm_pkg::CTRL_STOP]) begin
      stop_req_q <= 1'b1;
    end else if (any_err) begin
      run_q      <= 1'b0;
    end
  end

  // ****************************************
  // Input FIFO
  // ****************************************
  // Marker travels with each sample inside the FIFO only
  asbm_in_fifo #(
    .DEPTH_LOG2 (FIFO_DEPTH_LOG2)
  ) u_fifo (
    .sys_clk (sys_clk),
    .reset   (reset),
    .flush   (sel_ctrl && reg_wdata[asbm_pkg::CTRL_RUN]),
    .wr_en   (acq_en && adc_done),
    .wr_data (adc_data),
    .wr_post (trig_s_q[1]),
    .rd      (fif.src)
  );
  assign fifo_full = fif.full;

  // ****************************************
  // Pair packing and master writes
  // ****************************************
  asbm_state_t             st_q;
  logic [SW-1:0]           even_q;
  logic [SW-1:0]           conv;

  // Bipolar codes are two's complement from the converter; flip sign for offset binary
  assign conv = bipolar_q ? {~fif.data[SW-1], fif.data[SW-2:0]} : fif.data;
  assign fif.ready = (st_q == ASBM_EVEN || st_q == ASBM_ODD) && !any_err;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q      <= ASBM_IDLE;
      even_q    <= '0;
      mst_req   <= 1'b0;
      mst_data  <= '0;
      post_seen_q <= 1'b0;
      trig_valid_q <= 1'b0;
      trig_pos_q <= '0;
    end else if (any_err) begin
      st_q    <= ASBM_IDLE;
      mst_req <= 1'b0;
    end else if (run_wr) begin
      // A run write restarts from an even sample, so no stale half pair survives
      st_q         <= ASBM_EVEN;
      mst_req      <= 1'b0;
      trig_valid_q <= 1'b0;
      post_seen_q  <= 1'b0;
    end else begin
      case (st_q)
        ASBM_IDLE: begin
          st_q <= ASBM_IDLE;
        end
        ASBM_EVEN: begin
          if (fif.valid) begin
            even_q <= conv;
            st_q   <= ASBM_ODD;
            if (fif.post && !post_seen_q) begin
              post_seen_q  <= 1'b1;
              trig_valid_q <= 1'b1;
              trig_pos_q   <= {14'h0, widx_q, 2'h0};
            end
          end else if (stop_req_q) begin
            st_q <= ASBM_IDLE;
          end
        end
        ASBM_ODD: begin
          if (fif.valid) begin
            mst_data <= {conv, even_q};
            mst_req  <= 1'b1;
            st_q     <= ASBM_SEND;
            if (fif.post && !post_seen_q) begin
              post_seen_q  <= 1'b1;
              trig_valid_q <= 1'b1;
              trig_pos_q   <= {14'h0, widx_q, 2'h2};
            end
          end else if (stop_req_q) begin
            // Odd sample missing: send a full pair anyway
            // The host drops the duplicated upper half
            mst_data <= {even_q, even_q};
            mst_req  <= 1'b1;
            st_q     <= ASBM_SEND;
          end
        end
        ASBM_SEND: begin
          // Request and word stand until the host takes them; an error or a run write drops the request
          if (mst_ack) begin
            mst_req <= 1'b0;
            st_q    <= ASBM_EVEN;
          end
        end
        default: st_q <= ASBM_IDLE;
      endcase
    end
  end

  // ****************************************
  // Ring pointer and half tracking
  // ****************************************
  logic last_in_half;
  assign last_in_half = (widx_q[asbm_pkg::WIDX_W-2:0] == '1);

  // The word index wraps by itself at the ring end, back to the first half
  always_ff @(posedge sys_clk) begin
    if (reset || (sel_ctrl && reg_wdata[asbm_pkg::CTRL_RUN])) begin
      widx_q <= '0;
    end else if (st_q == ASBM_SEND && mst_ack && !any_err) begin
      widx_q <= widx_q + 1'b1;
    end
  end

  // Finishing one half while the other is still unconsumed would overwrite host data
  assign set_blk  = (st_q == ASBM_SEND) && mst_ack && last_in_half &&
                    half_done_q[~widx_q[asbm_pkg::WIDX_W-1]];

  // A finish and a consumed write in one cycle: the finish wins
  always_ff @(posedge sys_clk) begin
    if (reset || (sel_ctrl && reg_wdata[asbm_pkg::CTRL_RUN])) begin
      half_done_q <= 2'h0;
    end else begin
      for (int h = 0; h < 2; h++) begin
        if (st_q == ASBM_SEND && mst_ack && last_in_half &&
            widx_q[asbm_pkg::WIDX_W-1] == h[0]) begin
          half_done_q[h] <= 1'b1;
        end else if (consumed_wr[h]) begin
          half_done_q[h] <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // Read data stand until the next read strobe
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (reg_addr == asbm_pkg::REG_CTRL) begin
        reg_rdata <= {29'h0, bipolar_q, stop_req_q, run_q};
      end else if (reg_addr == asbm_pkg::REG_STATUS) begin
        reg_rdata <= {28'h0, trig_valid_q, fifo_full, st_q != ASBM_IDLE, run_q};
      end else if (reg_addr == asbm_pkg::REG_ERR) begin
        reg_rdata <= {29'h0, err_q};
      end else if (reg_addr == asbm_pkg::REG_BASE) begin
        reg_rdata <= base_q;
      end else if (reg_addr == asbm_pkg::REG_WPTR) begin
        reg_rdata <= {14'h0, widx_q, 2'h0};
      end else if (reg_addr == asbm_pkg::REG_TRIGPOS) begin
        reg_rdata <= trig_pos_q;
      end else if (reg_addr == asbm_pkg::REG_HALFDONE) begin
        reg_rdata <= {30'h0, half_done_q};
      end else begin
        reg_rdata <= '0;
      end
    end
  end

  // ****************************************
  // Output flops
  // ****************************************
  // Address is registered so the port never glitches while the pointer steps;
  // the pointer settles at least two cycles before the next request rises
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mst_addr <= asbm_pkg::BASE_RST;
    end else begin
      mst_addr <= base_q + {14'h0, widx_q, 2'h0};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      acq_run <= 1'b0;
    end else begin
      acq_run <= acq_en;
    end
  end
endmodule
`default_nettype wire

// file: asbm_top_asserts.sv
// Checker for asbm_top: register port and bus-master write port.
// Assumes only the top ports; the ring base is shadowed from register writes.
`timescale 1ns/1ps
`default_nettype none
module asbm_top_asserts #(
  parameter int unsigned FIFO_DEPTH_LOG2 = 4
) (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        mst_req,
  input wire logic [31:0] mst_addr,
  input wire logic [31:0] mst_data,
  input wire logic        mst_ack,
  input wire logic        acq_run
);
  logic [31:0] base_q;
  logic [31:0] offs;
  // Shadow of the base so ring bounds can be judged from the ports
  always_ff @(posedge sys_clk) begin
    if (reset) base_q <= asbm_pkg::BASE_RST;
    else if (reg_wr && reg_addr == asbm_pkg::REG_BASE) base_q <= reg_wdata;
  end
  assign offs = mst_addr - base_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ********************
  // Properties
  // ********************
  sequence s_wait; mst_req && !mst_ack; endsequence
  sequence s_take; mst_req && mst_ack; endsequence
  sequence s_err; reg_rd && reg_addr == asbm_pkg::REG_ERR ##1 reg_rdata[2:0] != 3'h0; endsequence
  data_hold_a: assert property (s_wait |=> !mst_req || $stable(mst_data))
    else $error("word changed before ack");
  ack_drop_a: assert property (s_take |=> !mst_req)
    else $error("request held after ack");
  err_halt_a: assert property (s_err |-> !acq_run && !mst_req)
    else $error("running with error set");
  ring_bound_a: assert property (mst_req |-> offs < asbm_pkg::RING_BYTES)
    else $error("address outside ring");
  addr_align_a: assert property (mst_req |-> mst_addr[1:0] == 2'h0)
    else $error("address not word aligned");
  unmapped_rd_a: assert property (reg_rd && reg_addr > asbm_pkg::REG_HALFDONE |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  reset_quiet_a: assert property ($fell(reset) |-> !mst_req && !acq_run && reg_rdata == 32'h0)
    else $error("outputs busy after reset");
endmodule
bind asbm_top asbm_top_asserts #(.FIFO_DEPTH_LOG2(FIFO_DEPTH_LOG2)) u_chk (.sys_clk(sys_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .mst_req(mst_req), .mst_addr(mst_addr), .mst_data(mst_data), .mst_ack(mst_ack), .acq_run(acq_run));
`default_nettype wire

// file: asbm_host_mem.sv
// Host memory model: accepts bus-master words after a set latency.
// Assumes one word outstanding at a time on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module asbm_host_mem (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        stall,
  input  wire logic [3:0]  lat,
  input  wire logic        mst_req,
  input  wire logic [31:0] mst_addr,
  input  wire logic [31:0] mst_data,
  output logic             mst_ack,
  output logic      [31:0] last_addr,
  output logic      [31:0] last_data,
  output logic      [15:0] n_words
);
  logic [3:0] wait_q;
  // ********************
  // Acceptance
  // ********************
  // Stall stands for a busy bus, so the device must live with any wait
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mst_ack <= 1'b0;
      wait_q  <= 4'h0;
      n_words <= 16'h0;
    end else if (mst_req && !mst_ack && !stall && wait_q >= lat) begin
      mst_ack   <= 1'b1;
      last_addr <= mst_addr;
      last_data <= mst_data;
      n_words   <= n_words + 16'h1;
      wait_q    <= 4'h0;
    end else begin
      mst_ack <= 1'b0;
      wait_q  <= mst_req ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// file: tb_top.sv
// Testbench for asbm_top with a host memory model on the write port.
// Assumes a small input FIFO so that overflow is reachable.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic bip; logic [15:0] ev; logic [15:0] od; logic [31:0] ex;} asbm_row_t;
  logic        sys_clk, reset, reg_wr, reg_rd, sample_clk, adc_busy, adc_done, trig_post;
  logic        mst_req, mst_ack, acq_run, stall;
  logic [3:0]  reg_addr, lat;
  logic [15:0] adc_data, n_words;
  logic [31:0] reg_wdata, reg_rdata, mst_addr, mst_data, last_addr, last_data;
  int          err_count, n_compared, cyc;
  asbm_row_t   rows [4];
  asbm_top #(.FIFO_DEPTH_LOG2(2)) u_dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_clk(sample_clk), .adc_busy(adc_busy), .adc_done(adc_done), .adc_data(adc_data),
    .trig_post(trig_post), .mst_req(mst_req), .mst_addr(mst_addr), .mst_data(mst_data),
    .mst_ack(mst_ack), .acq_run(acq_run));
  asbm_host_mem u_host (.sys_clk(sys_clk), .reset(reset), .stall(stall), .lat(lat), .mst_req(mst_req),
    .mst_addr(mst_addr), .mst_data(mst_data), .mst_ack(mst_ack), .last_addr(last_addr),
    .last_data(last_data), .n_words(n_words));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ********************
  // Tasks
  // ********************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string nm);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata, e);
  endtask
  task automatic smp(input logic [15:0] v);
    @(posedge sys_clk);
    sample_clk <= 1'b1;
    adc_data   <= v;
    adc_done   <= 1'b1;
    @(posedge sys_clk);
    sample_clk <= 1'b0;
    adc_done   <= 1'b0;
  endtask
  // Bounded wait for the host model to have taken n words
  task automatic words(input int n);
    int k = 0;
    while (n_words < n && k < 300) begin
      @(posedge sys_clk);
      k++;
    end
    #1 chk("word count", {16'h0, n_words}, 32'(n));
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  // ********************
  // Sequence
  // ********************
  initial begin
    rows[0] = '{1'b0, 16'h1234, 16'h5678, 32'h5678_1234};
    rows[1] = '{1'b0, 16'h0000, 16'hffff, 32'hffff_0000};
    rows[2] = '{1'b1, 16'h7ffe, 16'h8001, 32'h0001_fffe};
    rows[3] = '{1'b1, 16'hffff, 16'h0000, 32'h8000_7fff};
    {reg_wr, reg_rd, sample_clk, adc_busy, adc_done, trig_post, stall} = 7'h0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    adc_data = 16'h0;
    lat = 4'h0;
    reset = 1'b1;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    wr(4'h9, 32'hffff_ffff);
    for (int a = 0; a < 16; a++) rdc(4'(a), 32'h0, "reset value");
    wr(asbm_pkg::REG_BASE, 32'h0010_0000);
    foreach (rows[i]) begin
      lat <= 4'(i);
      wr(asbm_pkg::REG_CTRL, {29'h0, rows[i].bip, 2'b01});
      smp(rows[i].ev);
      smp(rows[i].od);
      words(i + 1);
      chk("pair data", last_data, rows[i].ex);
      chk("pair addr", last_addr, 32'h0010_0000);
      rdc(asbm_pkg::REG_WPTR, 32'h4, "write ptr");
    end
    // Stop with a lone sample still waiting for its partner
    wr(asbm_pkg::REG_CTRL, 32'h1);
    smp(16'h0abc);
    wr(asbm_pkg::REG_CTRL, 32'h2);
    words(5);
    chk("odd stop data", last_data, 32'h0abc_0abc);
    wr(asbm_pkg::REG_CTRL, 32'h1);
    smp(16'h0011);
    smp(16'h0022);
    trig_post <= 1'b1;
    repeat (4) @(posedge sys_clk);
    smp(16'h0033);
    smp(16'h0044);
    words(7);
    chk("post word", last_data, 32'h0044_0033);
    chk("post addr", last_addr, 32'h0010_0004);
    rdc(asbm_pkg::REG_TRIGPOS, 32'h4, "trigger pos");
    trig_post <= 1'b0;
    wr(asbm_pkg::REG_CTRL, 32'h1);
    rdc(asbm_pkg::REG_STATUS, 32'h3, "restart status");
    adc_busy <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sample_clk <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sample_clk <= 1'b0;
    rdc(asbm_pkg::REG_ERR, 32'h1, "overrun");
    chk("halted", {31'h0, acq_run}, 32'h0);
    smp(16'h0055);
    smp(16'h0066);
    rdc(asbm_pkg::REG_ERR, 32'h1, "overrun held");
    chk("no transfer", {16'h0, n_words}, 32'h7);
    wr(asbm_pkg::REG_ERR, 32'h1);
    adc_busy <= 1'b0;
    rdc(asbm_pkg::REG_ERR, 32'h0, "overrun clear");
    // Stalled host lets the small FIFO fill up
    stall <= 1'b1;
    wr(asbm_pkg::REG_CTRL, 32'h1);
    for (int s = 0; s < 12; s++) smp(16'(s));
    rdc(asbm_pkg::REG_ERR, 32'h2, "fifo overflow");
    rdc(asbm_pkg::REG_STATUS, 32'h4, "status full");
    wr(asbm_pkg::REG_ERR, 32'h2);
    rdc(asbm_pkg::REG_ERR, 32'h2, "fifo reraise");
    stall <= 1'b0;
    wr(asbm_pkg::REG_CTRL, 32'h1);
    wr(asbm_pkg::REG_ERR, 32'h2);
    rdc(asbm_pkg::REG_ERR, 32'h0, "fifo clear");
    wr(asbm_pkg::REG_HALFDONE, 32'h3);
    rdc(asbm_pkg::REG_HALFDONE, 32'h0, "halves free");
    print_verdict();
  end
endmodule
`default_nettype wire
